// file: src/reader_protocol_timers.sv
// reader protocol timers: receive mask, no-response, general purpose, wake-up
// assumes commands, events and carrier/rc ticks are sys_clk one-cycle pulses
// assumes configuration only changes while the matching timer is stopped
// assumes the host owns the transmit-end interrupt used to pace the timers
// Operation
// R01: controller writes configuration only while stopped
// R02: clear command stops all but wake-up
// R03: unconditional mode keeps no-response running on clear
// R04: tx end starts mask and no-response
// R05: mask running holds receive window low
// R06: squelch during mask; mask never interrupts
// R07: active peer mode: mask starts on field
// R08: low-power target: command start, step 512
// R09: no-response expiry raises its interrupt flag
// R10: step select 64 or 4096 carrier periods
// R11: mode 0: early reply stops, expiry interrupts
// R12: mode 1: always interrupt, window if idle
// R13: start command starts or restarts no-response
// R14: active peer mode ignores no-response start
// R15: active peer: expiry before field interrupts
// R16: controller reads transmit-end for synchronisation
// R17: general purpose trigger is selectable
// R18: general purpose expiry always interrupts
// R19: start command starts or restarts general
// R20: wake-up start accepted except wake-up mode
// R21: wake-up expiry sets flag and interrupts
// R22: only wake-up timer runs in low power
`timescale 1ns/1ps
`default_nettype none
module reader_protocol_timers (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic carrier_tick,
  input wire logic rc_tick,
  input wire proto_timers_pkg::cmd_t cmd,
  input wire proto_timers_pkg::evt_t evt,
  input wire proto_timers_pkg::cfg_t cfg,
  input wire logic reply_busy,
  output logic rx_window,
  output logic squelch_on,
  output logic rc_osc_en,
  output proto_timers_pkg::irq_t irq,
  output logic mask_running,
  output logic nrt_running,
  output logic gpt_running,
  output logic wut_running
);
  // crystal timers only count while not in low power
  logic xtal_tick;
  // step enables from dividers
  logic mask_step;
  logic nrt_step;
  logic gpt_step;
  // divide ratios
  // sized for the longest step of the no-response timer
  logic [proto_timers_pkg::PRE_W-1:0] mask_ratio;
  logic [proto_timers_pkg::PRE_W-1:0] nrt_ratio;
  // counters
  // each loaded at start and counted down one per step, the wake-up one per rc tick
  logic [proto_timers_pkg::MASK_W-1:0] mask_cnt;
  logic [proto_timers_pkg::NRT_W-1:0] nrt_cnt;
  logic [proto_timers_pkg::GPT_W-1:0] gpt_cnt;
  logic [proto_timers_pkg::WUT_TICK_W-1:0] wut_cnt;
  logic [proto_timers_pkg::WUT_TICK_W-1:0] wut_limit;
  // start and expiry strobes
  // all one-cycle, combinational from the current state
  logic mask_start;
  logic nrt_start;
  logic gpt_start;
  logic wut_start;
  logic mask_expire;
  logic nrt_expire;
  logic gpt_expire;
  logic wut_expire;
  // no-response forced window closure
  // set by expiry, cleared by the next frame
  logic nrt_block;
  // low-power target observe-after-mask flag
  // only meaningful while the target mode bit is set
  logic lp_observe;

  // the crystal is stopped in low power; gating here keeps a stale
  // carrier tick from moving any crystal-clocked counter
  // R22: crystal ticks gated
  assign xtal_tick = carrier_tick && !cfg.low_power;

  // step lengths in carrier periods, picked per mode; a change takes
  // effect within the running step since the dividers compare against the live ratio
  // R08: extra divide by eight
  assign mask_ratio = cfg.lp_target ? proto_timers_pkg::PRE_W'(proto_timers_pkg::MASK_LP_DIV)
                                    : proto_timers_pkg::PRE_W'(proto_timers_pkg::MASK_STEP_DIV);
  // R10: no-response step select
  assign nrt_ratio = cfg.nrt_step_long ? proto_timers_pkg::PRE_W'(proto_timers_pkg::NRT_STEP_LONG)
                                       : proto_timers_pkg::PRE_W'(proto_timers_pkg::NRT_STEP_SHORT);

  // exactly one source arms the mask in each mode, so a stray transmit
  // end cannot reopen the mask in peer or target operation
  // mask start sources
  always_comb begin
    mask_start = 1'b0;
    if (cfg.lp_target) begin
      // R08: command start only
      mask_start = cmd.start_mask;
    end else if (cfg.active_p2p) begin
      // R07: peer field starts
      mask_start = evt.peer_field_on;
    end else begin
      // R04: end of transmission
      mask_start = evt.tx_end;
    end
  end

  // transmit end always arms it; the host command is a way to stretch
  // the timeout past one counter load
  // no-response start sources
  always_comb begin
    // R04: tx end starts it
    nrt_start = evt.tx_end;
    // R13: command start; R14: not in active peer
    if (cmd.start_nrt && !cfg.active_p2p) begin
      nrt_start = 1'b1;
    end
  end

  // the command works in every mode; the frame or field trigger is
  // taken only from the source chosen in the configuration
  // general purpose start sources
  always_comb begin
    // R19: command start or restart
    gpt_start = cmd.start_gpt;
    // R17: selectable trigger
    case (cfg.gpt_trig)
      proto_timers_pkg::GPT_TRIG_RX_START: begin
        if (evt.rx_sof) gpt_start = 1'b1;
      end
      proto_timers_pkg::GPT_TRIG_RX_END: begin
        if (evt.rx_eof) gpt_start = 1'b1;
      end
      proto_timers_pkg::GPT_TRIG_FIELD_OFF: begin
        if (cfg.active_p2p && evt.peer_field_off) gpt_start = 1'b1;
      end
      default: begin
        // no hardware trigger, command only
      end
    endcase
  end

  // in wake-up mode the wake-up timer belongs to the measurement loop
  // R20: wake-up start refused in wake-up mode
  assign wut_start = cmd.start_wut && !cfg.wakeup_mode;

  // comparing with one, not zero, ends an N-step timer on its Nth step
  // and keeps a counter loaded with one from wrapping round
  // expiry strobes at count one on a step
  assign mask_expire = mask_running && mask_step && (mask_cnt <= proto_timers_pkg::MASK_W'(1));
  assign nrt_expire = nrt_running && nrt_step && (nrt_cnt <= proto_timers_pkg::NRT_W'(1));
  assign gpt_expire = gpt_running && gpt_step && (gpt_cnt <= proto_timers_pkg::GPT_W'(1));
  assign wut_expire = wut_running && rc_tick && (wut_cnt <= proto_timers_pkg::WUT_TICK_W'(1));

  // a setting of zero still gives one full step, never an instant expiry
  // wake-up timeout in rc ticks, ten ms per step plus one
  assign wut_limit = proto_timers_pkg::WUT_TICK_W'(({13'h0000, cfg.wut_sel} + 16'h0001)
                     * proto_timers_pkg::WUT_UNIT_TICKS);

  // each divider restarts with its timer, so the first step is a full one
  // mask step divider
  step_divider #(.W(proto_timers_pkg::PRE_W)) u_mask_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_en(xtal_tick),
    .restart(mask_start),
    .ratio(mask_ratio),
    .step_en(mask_step)
  );

  // its ratio follows the step-select bit live, within a running step as well as at a start
  // no-response step divider
  step_divider #(.W(proto_timers_pkg::PRE_W)) u_nrt_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_en(xtal_tick),
    .restart(nrt_start),
    .ratio(nrt_ratio),
    .step_en(nrt_step)
  );

  // fixed ratio, the trigger choice only moves the start
  // general purpose step divider
  step_divider #(.W(proto_timers_pkg::PRE_W)) u_gpt_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_en(xtal_tick),
    .restart(gpt_start),
    .ratio(proto_timers_pkg::PRE_W'(proto_timers_pkg::GPT_STEP_DIV)),
    .step_en(gpt_step)
  );

  // clear beats a start in the same cycle; expiry is silent, the window
  // simply reopens when the mask drops
  // mask receive timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_running <= 1'b0;
      mask_cnt <= proto_timers_pkg::MASK_RESET;
    end else if (cmd.clear) begin
      // R02: clear stops it
      mask_running <= 1'b0;
    end else if (mask_start) begin
      // zero setting means no mask
      mask_running <= (cfg.mask_time != proto_timers_pkg::MASK_RESET);
      mask_cnt <= cfg.mask_time;
    end else if (mask_expire) begin
      // R06: silent expiry
      mask_running <= 1'b0;
    end else if (mask_running && mask_step) begin
      mask_cnt <= mask_cnt - proto_timers_pkg::MASK_W'(1);
    end
  end

  // until the mask from the latest start expires the receiver output is ignored, so the
  // window stays shut in target mode
  // low-power target: receiver observed after mask expiry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_observe <= 1'b0;
    end else if (!cfg.lp_target || cmd.clear || mask_start) begin
      lp_observe <= 1'b0;
    end else if (mask_expire) begin
      // R08: watch receiver
      lp_observe <= 1'b1;
    end
  end

  // branch order sets priority: clear, then start, then expiry, then
  // the reply or field that ends the wait early; an early stop never
  // raises an interrupt
  // no-response timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nrt_running <= 1'b0;
      nrt_cnt <= proto_timers_pkg::NRT_RESET;
    end else if (cmd.clear && !cfg.nrt_uncond) begin
      // R02: clear stops; R03: not in unconditional mode
      nrt_running <= 1'b0;
    end else if (nrt_start) begin
      // R13: reset and restart
      nrt_running <= (cfg.nrt_time != proto_timers_pkg::NRT_RESET);
      nrt_cnt <= cfg.nrt_time;
    end else if (nrt_expire) begin
      nrt_running <= 1'b0;
    end else if (nrt_running && !cfg.nrt_uncond && !cfg.active_p2p && evt.rx_sof) begin
      // R11: early reply stops silently
      nrt_running <= 1'b0;
    end else if (nrt_running && cfg.active_p2p && evt.peer_field_on) begin
      // R15: peer answered in time
      nrt_running <= 1'b0;
    end else if (nrt_running && nrt_step) begin
      nrt_cnt <= nrt_cnt - proto_timers_pkg::NRT_W'(1);
    end
  end

  // a restart reloads the count and the prescaler phase together
  // general purpose timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpt_running <= 1'b0;
      gpt_cnt <= proto_timers_pkg::GPT_RESET;
    end else if (cmd.clear) begin
      // R02: clear stops it
      gpt_running <= 1'b0;
    end else if (gpt_start) begin
      // R19: reset and restart
      gpt_running <= (cfg.gpt_time != proto_timers_pkg::GPT_RESET);
      gpt_cnt <= cfg.gpt_time;
    end else if (gpt_expire) begin
      gpt_running <= 1'b0;
    end else if (gpt_running && gpt_step) begin
      gpt_cnt <= gpt_cnt - proto_timers_pkg::GPT_W'(1);
    end
  end

  // not touched by clear and not gated by low power, so it can wake the
  // system from the lowest power state
  // wake-up timer on rc oscillator ticks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wut_running <= 1'b0;
      wut_cnt <= '0;
    end else if (wut_start) begin
      // R20: start from control setting
      wut_running <= 1'b1;
      wut_cnt <= wut_limit;
    end else if (wut_expire) begin
      wut_running <= 1'b0;
    end else if (wut_running && rc_tick) begin
      wut_cnt <= wut_cnt - proto_timers_pkg::WUT_TICK_W'(1);
    end
  end

  // stopping it when idle saves the oscillator current
  // rc oscillator runs while wake-up timer is armed
  assign rc_osc_en = wut_running;

  // window closure forced by no-response expiry
  // an expiry beats a clear or a mask start in the same cycle, so an
  // unconditional timeout with no reply busy still closes the window; only a restart of
  // the no-response timer itself cancels the expiry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nrt_block <= 1'b0;
    end else if (nrt_expire && !nrt_start) begin
      if (!cfg.nrt_uncond) begin
        // R11: force window low
        nrt_block <= 1'b1;
      end else begin
        // R12: only if no reply in progress
        nrt_block <= !reply_busy;
      end
    end else if (nrt_start || mask_start || cmd.clear) begin
      // new frame reopens window
      nrt_block <= 1'b0;
    end
  end

  // registered so each pulse is glitch free and lands one cycle after
  // the step that ended the count
  // interrupt pulses, one cycle each
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= '0;
    end else begin
      // R09: no-response flag; R12: unconditional; R15: peer
      irq.nrt_irq <= nrt_expire;
      // R18: every general expiry
      irq.gpt_irq <= gpt_expire;
      // R21: wake-up flag
      irq.wakeup_timer_irq_flag <= wut_expire;
    end
  end

  // the window is open only when no timer holds it shut
  // R05: mask closes window
  assign rx_window = !mask_running && !nrt_block && (!cfg.lp_target || lp_observe);
  // R06: squelch while masking
  assign squelch_on = mask_running && cfg.squelch_en;
endmodule
`default_nettype wire

// file: src/proto_timers_pkg.sv
// package for the reader protocol timers: timing constants, modes, port bundles
// assumes a single 10 MHz system clock; carrier ticks arrive as enables
package proto_timers_pkg;
  // system clock period in ns
  localparam int SYS_CLK_NS = 100;
  // counter widths
  localparam int MASK_W = 8;
  localparam int NRT_W = 16;
  localparam int GPT_W = 16;
  localparam int WUT_W = 3;
  // carrier-clock divide ratios per count step
  localparam int MASK_STEP_DIV = 64;
  localparam int MASK_LP_DIV = 512;
  localparam int NRT_STEP_SHORT = 64;
  localparam int NRT_STEP_LONG = 4096;
  localparam int GPT_STEP_DIV = 8;
  // prescaler width, enough for the longest step
  localparam int PRE_W = 13;
  // wake-up timeout table unit: rc oscillator ticks per 10 ms step
  localparam int WUT_UNIT_TICKS = 320;
  localparam int WUT_TICK_W = 16;
  // reset values of configuration
  localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;
  localparam logic [NRT_W-1:0] NRT_RESET = 16'h0000;
  localparam logic [GPT_W-1:0] GPT_RESET = 16'h0000;
  localparam logic [WUT_W-1:0] WUT_RESET = 3'h4;

  // general purpose timer trigger choice
  typedef enum logic [1:0] {
    GPT_TRIG_NONE,
    GPT_TRIG_RX_START,
    GPT_TRIG_RX_END,
    GPT_TRIG_FIELD_OFF
  } gpt_trig_t;

  // direct commands, one-cycle pulses
  typedef struct packed {
    logic clear;
    logic start_mask;
    logic start_nrt;
    logic start_gpt;
    logic start_wut;
  } cmd_t;

  // frame and field events, one-cycle pulses
  typedef struct packed {
    logic tx_end;
    logic rx_sof;
    logic rx_eof;
    logic peer_field_on;
    logic peer_field_off;
  } evt_t;

  // configuration bits
  typedef struct packed {
    logic [MASK_W-1:0] mask_time;
    logic [NRT_W-1:0] nrt_time;
    logic nrt_step_long;
    logic nrt_uncond;
    logic [GPT_W-1:0] gpt_time;
    gpt_trig_t gpt_trig;
    logic [WUT_W-1:0] wut_sel;
    logic squelch_en;
    logic active_p2p;
    logic lp_target;
    logic wakeup_mode;
    logic low_power;
  } cfg_t;

  // interrupt pulses and status
  typedef struct packed {
    logic nrt_irq;
    logic gpt_irq;
    logic wakeup_timer_irq_flag;
  } irq_t;
endpackage

// file: src/step_divider.sv
// free-running divider making one-cycle step enables from a tick enable
// assumes tick_en is on sys_clk; restart clears the phase
`timescale 1ns/1ps
`default_nettype none
module step_divider #(
  parameter int W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick_en,
  input wire logic restart,
  input wire logic [W-1:0] ratio,
  output logic step_en
);
  // ticks counted within the current step
  logic [W-1:0] phase;

  // count ticks, pulse when ratio reached
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
      step_en <= 1'b0;
    end else if (restart) begin
      phase <= '0;
      step_en <= 1'b0;
    end else if (tick_en && (phase == ratio - W'(1))) begin
      phase <= '0;
      step_en <= 1'b1;
    end else begin
      step_en <= 1'b0;
      if (tick_en) begin
        phase <= phase + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/proto_timers_monitor.sv
// checker for the protocol timers, top ports only
// assumes binding onto reader_protocol_timers
`timescale 1ns/1ps
`default_nettype none
module proto_timers_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire proto_timers_pkg::cmd_t cmd,
  input wire proto_timers_pkg::evt_t evt,
  input wire proto_timers_pkg::cfg_t cfg,
  input wire logic reply_busy,
  input wire logic rx_window,
  input wire logic squelch_on,
  input wire logic rc_osc_en,
  input wire proto_timers_pkg::irq_t irq,
  input wire logic mask_running,
  input wire logic nrt_running,
  input wire logic gpt_running,
  input wire logic wut_running
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  clear_stops_a: assert property (cmd.clear |=> !mask_running && !gpt_running)
    else $error("clear left a timer running");
  mask_window_a: assert property (mask_running |-> !rx_window)
    else $error("window open while masked");
  squelch_mask_a: assert property (squelch_on == (mask_running && cfg.squelch_en))
    else $error("squelch does not follow mask");
  txend_mask_a: assert property (evt.tx_end && !cfg.active_p2p && !cfg.lp_target
    && cfg.mask_time != 8'h00 && !cmd.clear && !cfg.low_power |=> mask_running)
    else $error("mask not started by transmit end");
  peer_nrt_a: assert property (cmd.start_nrt && cfg.active_p2p && !nrt_running
    && evt == '0 |=> !nrt_running) else $error("no-response start taken in peer mode");
  wut_refuse_a: assert property (cmd.start_wut && cfg.wakeup_mode && !wut_running
    |=> !wut_running) else $error("wake-up start taken in wake-up mode");
  rc_osc_a: assert property (rc_osc_en == wut_running)
    else $error("rc oscillator not tied to wake-up timer");
  nrt_block_a: assert property (irq.nrt_irq && !$past(reply_busy) && !$past(cmd.start_nrt)
    && !$past(evt.tx_end) |-> !rx_window) else $error("window open after no-response expiry");
  wut_irq_a: assert property ($fell(wut_running) |-> ##[0:1] irq.wakeup_timer_irq_flag)
    else $error("wake-up expiry without flag");
  gpt_irq_a: assert property ($fell(gpt_running) && !$past(cmd.clear)
    |-> ##[0:1] irq.gpt_irq) else $error("general expiry without interrupt");
  cover property (irq.nrt_irq);
  cover property (irq.gpt_irq);
  cover property (irq.wakeup_timer_irq_flag);
endmodule
bind reader_protocol_timers proto_timers_monitor i_mon (.sys_clk, .rst_n, .cmd, .evt, .cfg,
  .reply_busy, .rx_window, .squelch_on, .rc_osc_en, .irq, .mask_running, .nrt_running,
  .gpt_running, .wut_running);
`default_nettype wire

// file: testbench/proto_ctrl_model.sv
// tick source at the far side: carrier clock and rc oscillator
// assumes one sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module proto_ctrl_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rc_osc_en,
  output logic carrier_tick,
  output logic rc_tick
);
  // rc phase, one tick in four clocks
  logic [1:0] rc_phase;
  // carrier ticks run on in low power; the block must ignore them
  assign carrier_tick = rst_n;
  // rc oscillator runs only once started
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_phase <= 2'h0;
    end else begin
      rc_phase <= rc_osc_en ? rc_phase + 2'h1 : 2'h0;
    end
  end
  assign rc_tick = rc_osc_en & (rc_phase == 2'h3);
endmodule
`default_nettype wire

// file: testbench/reader_protocol_timers_bench.sv
// self-checking bench for the protocol timers
// assumes the tick model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module reader_protocol_timers_bench;
  logic sys_clk, rst_n, carrier_tick, rc_tick, reply_busy, hit;
  logic rx_window, squelch_on, rc_osc_en, mask_running, nrt_running, gpt_running, wut_running;
  proto_timers_pkg::cmd_t cmd;
  proto_timers_pkg::evt_t evt;
  proto_timers_pkg::cfg_t cfg, nc;
  proto_timers_pkg::irq_t irq;
  int error_cnt, checks_done, cycles;
  reader_protocol_timers i_dut (.sys_clk, .rst_n, .carrier_tick, .rc_tick, .cmd, .evt, .cfg,
    .reply_busy, .rx_window, .squelch_on, .rc_osc_en, .irq, .mask_running, .nrt_running,
    .gpt_running, .wut_running);
  proto_ctrl_model i_ctrl (.sys_clk, .rst_n, .rc_osc_en, .carrier_tick, .rc_tick);
  // clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle command and event pulse
  task pulse(input logic [4:0] c, input logic [4:0] e);
    @(posedge sys_clk);
    cmd <= c;
    evt <= e;
    @(posedge sys_clk);
    cmd <= '0;
    evt <= '0;
    #1;
  endtask
  // wait n cycles noting interrupt bit b
  task run_for(input int n, input int b);
    hit = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      hit |= irq[b];
    end
  endtask
  task apply();
    @(posedge sys_clk);
    cfg <= nc;
    @(posedge sys_clk);
    #1;
  endtask
  task t_mask();
    nc = '0;
    nc.mask_time = 8'h02;
    nc.squelch_en = 1'b1;
    apply();
    pulse(5'h00, 5'h10);
    check({mask_running, rx_window, squelch_on}, 3'b101);
    run_for(120, 2);
    check(mask_running, 1'b1);
    run_for(20, 2);
    check({mask_running, rx_window}, 2'b01);
    check(hit, 1'b0);
  endtask
  task t_nrt();
    nc = '0;
    nc.nrt_time = 16'h0001;
    apply();
    pulse(5'h00, 5'h10);
    check(nrt_running, 1'b1);
    run_for(80, 2);
    check({hit, nrt_running, rx_window}, 3'b100);
    pulse(5'h10, 5'h00);
    pulse(5'h00, 5'h10);
    run_for(10, 2);
    pulse(5'h00, 5'h08);
    run_for(80, 2);
    check({hit, nrt_running, rx_window}, 3'b001);
    pulse(5'h04, 5'h00);
    run_for(50, 2);
    pulse(5'h04, 5'h00);
    run_for(50, 2);
    check({hit, nrt_running}, 2'b01);
    run_for(30, 2);
    check(hit, 1'b1);
    nc.nrt_step_long = 1'b1;
    apply();
    pulse(5'h04, 5'h00);
    run_for(4000, 2);
    check({hit, nrt_running}, 2'b01);
    run_for(200, 2);
    check(hit, 1'b1);
  endtask
  task t_clear();
    nc = '0;
    nc.nrt_time = 16'h0001;
    nc.gpt_time = 16'h0100;
    nc.nrt_uncond = 1'b1;
    apply();
    pulse(5'h06, 5'h00);
    reply_busy <= 1'b1;
    pulse(5'h10, 5'h00);
    check({nrt_running, gpt_running}, 2'b10);
    pulse(5'h00, 5'h08);
    run_for(80, 2);
    check({hit, rx_window}, 2'b11);
    reply_busy <= 1'b0;
  endtask
  task t_gpt();
    for (int i = 1; i < 4; i++) begin
      nc = '0;
      nc.gpt_time = 16'h0002;
      nc.active_p2p = (i == 3);
      nc.gpt_trig = proto_timers_pkg::gpt_trig_t'(i);
      apply();
      pulse(5'h00, i == 1 ? 5'h08 : (i == 2 ? 5'h04 : 5'h01));
      check(gpt_running, 1'b1);
      run_for(30, 1);
      check({hit, gpt_running}, 2'b10);
    end
    pulse(5'h02, 5'h00);
    run_for(10, 1);
    pulse(5'h02, 5'h00);
    run_for(10, 1);
    check({hit, gpt_running}, 2'b01);
    run_for(20, 1);
    check(hit, 1'b1);
  endtask
  task t_peer();
    nc = '0;
    nc.active_p2p = 1'b1;
    nc.nrt_time = 16'h0001;
    nc.mask_time = 8'h01;
    apply();
    pulse(5'h04, 5'h00);
    check(nrt_running, 1'b0);
    pulse(5'h00, 5'h02);
    check(mask_running, 1'b1);
    run_for(80, 2);
    pulse(5'h00, 5'h10);
    run_for(80, 2);
    check({hit, nrt_running}, 2'b10);
    pulse(5'h00, 5'h10);
    pulse(5'h00, 5'h02);
    run_for(80, 2);
    check({hit, nrt_running}, 2'b00);
  endtask
  task t_lp();
    nc = '0;
    nc.lp_target = 1'b1;
    nc.mask_time = 8'h01;
    apply();
    pulse(5'h00, 5'h10);
    check({mask_running, rx_window}, 2'b00);
    pulse(5'h08, 5'h00);
    check(mask_running, 1'b1);
    run_for(500, 2);
    check(mask_running, 1'b1);
    run_for(30, 2);
    check({mask_running, rx_window}, 2'b01);
  endtask
  task t_wake();
    nc = '0;
    nc.wakeup_mode = 1'b1;
    apply();
    pulse(5'h01, 5'h00);
    check(wut_running, 1'b0);
    nc.wakeup_mode = 1'b0;
    nc.low_power = 1'b1;
    nc.gpt_time = 16'h0001;
    apply();
    pulse(5'h02, 5'h00);
    run_for(40, 1);
    check({hit, gpt_running}, 2'b01);
    pulse(5'h11, 5'h00);
    pulse(5'h01, 5'h00);
    check({wut_running, rc_osc_en, gpt_running}, 3'b110);
    run_for(1400, 0);
    check({hit, wut_running}, 2'b10);
  endtask
  initial begin
    rst_n = 1'b0;
    reply_busy = 1'b0;
    cmd = '0;
    evt = '0;
    cfg = '0;
    nc = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check({rx_window, mask_running, nrt_running, gpt_running, wut_running}, 5'h10);
    t_mask();
    t_nrt();
    t_clear();
    t_gpt();
    t_peer();
    t_lp();
    t_wake();
    complete_run();
  end
endmodule
`default_nettype wire
